// ### bench/fps_conv_model.sv
// fps_conv_model: two cascaded flash converters sharing four result lines
// assumes the lower low-active enable and the upper high-active enable are tied together
`timescale 1ns/1ns
module fps_conv_model
    import fps_pkg::*;
(
    input wire logic conv_clk,
    input wire logic lower_oe_n,
    input wire logic upper_oe,
    input wire logic [4:0] lower_lvl,
    input wire logic [4:0] upper_lvl,
    output fps_pins_t lower_pins,
    output fps_pins_t upper_pins
);
    logic [4:0] lat_lo = 5'h00;
    logic [4:0] lat_up = 5'h00;
    logic [4:0] out_lo = 5'h00;
    logic [4:0] out_up = 5'h00;
    logic chg_lo = 1'b0;
    logic chg_up = 1'b0;
    logic [3:0] bus_last = 4'h0;
    wire logic drv = !lower_oe_n || upper_oe;
    // levels above 15 mean overflow with all bits high
    function automatic logic [4:0] quant(input logic [4:0] lvl);
        return (lvl > 5'h0f) ? 5'h1f : lvl;
    endfunction : quant
    // no edge, no conversion: either idle level simply waits
    always @(negedge conv_clk) begin
        lat_lo <= quant(lower_lvl);
        lat_up <= quant(upper_lvl);
    end
    always @(posedge conv_clk) begin
        chg_lo <= (lat_lo != out_lo);
        chg_up <= (lat_up != out_up);
        out_lo <= lat_lo;
        out_up <= lat_up;
    end
    // floating lines show the inverse of the last driven value
    wire logic [3:0] bus = !lower_oe_n ? out_lo[3:0] : upper_oe ? out_up[3:0] : ~bus_last;
    always @(bus) if (drv) bus_last = bus;
    assign lower_pins = {bus, out_lo[4], chg_lo};
    assign upper_pins = {bus, upper_oe ? {out_up[4], chg_up} : ~{out_up[4], chg_up}};
endmodule : fps_conv_model

// ### bench/tb_fps_ctrl.sv
// tb_fps_ctrl: register-level tests of the pulse-mode controller
// assumes the converter model answers on the converter clock pin
`timescale 1ns/1ns
module tb_fps_ctrl;
    import fps_pkg::*;
    localparam int unsigned DROOP = 10;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [1:0] addr = 2'h0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic conv_clk;
    logic lower_oe_n;
    logic upper_oe;
    fps_pins_t lower_pins;
    fps_pins_t upper_pins;
    logic [4:0] lower_lvl = 5'h00;
    logic [4:0] upper_lvl = 5'h00;
    int fail_count = 0;
    int compares = 0;
    int falls = 0;
    int rises = 0;
    logic [7:0] s;
    always #25 clk = ~clk;
    always @(negedge conv_clk) falls++;
    always @(posedge conv_clk) rises++;
    fps_ctrl #(.DROOP_CYC(DROOP)) fps_ctrl_inst (.CLK(clk), .RST(rst), .ADDR(addr),
        .WDATA(wdata), .WR(wr_en), .RD(rd_en), .RDATA(rdata), .CONV_CLK(conv_clk),
        .LOWER_PINS(lower_pins), .UPPER_PINS(upper_pins), .LOWER_OE_N(lower_oe_n),
        .UPPER_OE(upper_oe));
    fps_conv_model fps_conv_model_inst (.conv_clk(conv_clk), .lower_oe_n(lower_oe_n),
        .upper_oe(upper_oe), .lower_lvl(lower_lvl), .upper_lvl(upper_lvl),
        .lower_pins(lower_pins), .upper_pins(upper_pins));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic bus_wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : bus_wr
    task automatic bus_rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask : bus_rd
    task automatic wait_idle();
        repeat (3) @(posedge clk);
        for (int i = 0; i < 40; i++) begin
            bus_rd(A_STAT, s);
            if (s[0] === 1'b0) break;
        end
    endtask : wait_idle
    // mode writes are refused while busy, so retry until the readback agrees
    task automatic set_ctrl(input logic [7:0] v);
        for (int i = 0; i < 20; i++) begin
            bus_wr(A_CTRL, v);
            bus_rd(A_CTRL, s);
            if (s === (v & 8'h0e)) break;
        end
        chk(s, v & 8'h0e);
    endtask : set_ctrl
    // lower overflow becomes the msb and picks which device fills the low bits
    function automatic logic [7:0] exp_code(input logic [4:0] lo, input logic [4:0] up);
        if (lo > 5'h0f) return {3'h0, 1'b1, (up > 5'h0f) ? 4'hf : up[3:0]};
        return {3'h0, 1'b0, lo[3:0]};
    endfunction : exp_code
    // one request per mode; pulse counts and idle level tell the sequence apart
    task automatic conv(input logic [1:0] m, input logic [4:0] lo, input logic [4:0] up);
        int np;
        np = (m == 2'h0) ? 1 : 2;
        lower_lvl <= lo;
        upper_lvl <= up;
        bus_wr(A_CTRL, {5'h00, m, 1'b0});
        repeat (4) @(posedge clk);
        falls = 0;
        rises = 0;
        bus_wr(A_CTRL, {5'h00, m, 1'b1});
        wait_idle();
        chk(8'(falls), 8'(np));
        chk(8'(rises), 8'(np));
        chk({7'h00, conv_clk}, (m == 2'h1) ? 8'h00 : 8'h01);
        chk(s & 8'h03, 8'h02);
        bus_rd(A_DATA, s);
        chk(s & 8'h1f, exp_code(lo, up));
        chk({6'h00, lower_oe_n, upper_oe}, (lo > 5'h0f) ? 8'h03 : 8'h00);
        bus_rd(A_STAT, s);
        chk(s & 8'h02, 8'h00);
    endtask : conv
    task automatic final_report();
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : final_report
    initial begin
        #(50 * 20000);
        fail_count++;
        final_report();
    end
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk({7'h00, conv_clk}, 8'h01);
        bus_rd(A_STAT, s);
        chk(s, 8'h00);
        bus_rd(A_DATA, s);
        chk(s, 8'h00);
        bus_rd(2'h3, s);
        chk(s, 8'h00);
        conv(2'h0, 5'h03, 5'h00);
        conv(2'h1, 5'h09, 5'h02);
        conv(2'h2, 5'h10, 5'h05);
        conv(2'h0, 5'h10, 5'h10);
        conv(2'h1, 5'h00, 5'h07);
        conv(2'h2, 5'h0f, 5'h0c);
        // second start while busy is pended, not lost
        falls = 0;
        bus_wr(A_CTRL, 8'h01);
        bus_wr(A_CTRL, 8'h01);
        wait_idle();
        repeat (4) @(posedge clk);
        wait_idle();
        chk(8'(falls), 8'h02);
        // continuous clocking repeats without requests
        falls = 0;
        bus_wr(A_CTRL, 8'h06);
        repeat (40) @(posedge clk);
        chk(8'(falls >= 3), 8'h01);
        set_ctrl(8'h00);
        wait_idle();
        repeat (10) @(posedge clk);
        // keep-alive reconverts unrequested, at least twice within three droop periods
        bus_wr(A_CTRL, 8'h08);
        falls = 0;
        repeat (3 * DROOP) @(posedge clk);
        chk(8'(falls >= 2), 8'h01);
        set_ctrl(8'h00);
        wait_idle();
        final_report();
    end
endmodule : tb_fps_ctrl

// ### logic/fps_ctrl.sv
// fps_ctrl: host controller driving one or two cascaded flash converters
// assumes converter pins are asynchronous and pass two flip-flops here
// Operation
// - fast mode idles high, low pulse starts
// - next pulse within 20 ns to 5 us; keep-alive pulses start 5.4 us after the last rise
// - keep high time long, low short
// - low-idle mode may wait indefinitely
// - low-idle conversion uses two high pulses
// - low-idle conversion takes 40 ns
// - third mode: high idle, two lows
// - add output delay to conversion time
// - lower overflow flag is result msb
// - low bits chosen by lower overflow
// - lower overflow drives both output enables
// - both converters share result lines
`timescale 1ns/1ns
module fps_ctrl
    import fps_pkg::*;
#(
    parameter int unsigned DROOP_CYC = fps_pkg::C_DROOP
)
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic [1:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    output logic CONV_CLK,
    input wire fps_pins_t LOWER_PINS,
    input wire fps_pins_t UPPER_PINS,
    output logic LOWER_OE_N,
    output logic UPPER_OE
);
    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_P1 = 3'b001,
        S_GAP = 3'b010,
        S_P2 = 3'b011,
        S_DELAY = 3'b100,
        S_REST = 3'b101
    } fps_state_t;

    fps_state_t st_q;
    fps_state_t st_d;
    fps_mode_t mode_q;
    logic keep_q;
    logic pend_q;
    logic pend_d;
    logic valid_q;
    logic valid_d;
    logic droop_q;
    logic droop_d;
    logic clk_q;
    logic clk_d;
    logic [7:0] rdata_q;
    logic [15:0] idle_q;
    fps_pins_t lo_m_q;
    fps_pins_t lo_s_q;
    fps_pins_t up_m_q;
    fps_pins_t up_s_q;
    fps_result_t res_q;
    fps_result_t res_d;
    logic oe_sel_q;
    logic cnt_load;
    logic [CW-1:0] cnt_val;
    logic cnt_done;

    // software decode
    wire wr_ctrl = WR && (ADDR == A_CTRL);
    wire start_req = wr_ctrl && WDATA[B_START];
    wire busy = (st_q != S_IDLE);
    wire idle_level = (mode_q != FPS_LOW_IDLE);
    // continuous clocking: run sequences back to back
    wire cont = (mode_q == FPS_CONT);
    // no start in the cycle of a control write, so a sequence never mixes modes
    wire go = (st_q == S_IDLE) && !wr_ctrl && (pend_q || cont || (keep_q && droop_q));
    wire two_pulse = (mode_q == FPS_LOW_IDLE) || (mode_q == FPS_HIGH_IDLE2);
    wire [7:0] stat_word = {4'h0, droop_q, pend_q, valid_q, busy};
    wire [7:0] ctrl_word = {4'h0, keep_q, mode_q, 1'b0};
    wire [7:0] data_word = {2'h0, res_q.changed, res_q.code};
    wire rd_data = RD && (ADDR == A_DATA);
    wire capture = (st_q == S_DELAY) && cnt_done;

    // cascade selection from the synchronised lower overflow
    wire lo_over = lo_s_q.range_exceeded_flag;
    wire [3:0] low_bits = lo_over ? up_s_q.result_bits : lo_s_q.result_bits;
    wire chg = lo_over ? up_s_q.result_changed_flag : lo_s_q.result_changed_flag;

    fps_seq_cnt fps_seq_cnt_inst (
        .clk(CLK),
        .rst(RST),
        .load(cnt_load),
        .value(cnt_val),
        .done(cnt_done)
    );

    // sequencer: active phase = opposite of idle level
    always_comb begin
        st_d = st_q;
        clk_d = idle_level;
        cnt_load = 1'b0;
        cnt_val = '0;
        valid_d = valid_q;
        res_d = res_q;
        unique case (st_q)
            S_IDLE: begin
                if (go) begin
                    st_d = S_P1;
                    clk_d = ~idle_level;
                    cnt_load = 1'b1;
                    cnt_val = CW'(C_PULSE - 1);
                    valid_d = 1'b0;
                end
            end
            S_P1: begin
                clk_d = ~idle_level;
                if (cnt_done) begin
                    clk_d = idle_level;
                    cnt_load = 1'b1;
                    cnt_val = CW'(C_REPEAT - 1);
                    st_d = two_pulse ? S_GAP : S_DELAY;
                    if (!two_pulse) begin
                        cnt_val = CW'(C_OUTDLY + C_SETTLE);
                    end
                end
            end
            S_GAP: begin
                if (cnt_done) begin
                    st_d = S_P2;
                    clk_d = ~idle_level;
                    cnt_load = 1'b1;
                    cnt_val = CW'(C_PULSE - 1);
                end
            end
            S_P2: begin
                clk_d = ~idle_level;
                if (cnt_done) begin
                    clk_d = idle_level;
                    st_d = S_DELAY;
                    cnt_load = 1'b1;
                    cnt_val = CW'(C_OUTDLY + C_SETTLE);
                end
            end
            S_DELAY: begin
                // result edge already given; wait for output delay plus sync
                if (cnt_done) begin
                    st_d = S_REST;
                    res_d.code = {lo_over, low_bits};
                    res_d.changed = chg;
                    valid_d = 1'b1;
                    cnt_load = 1'b1;
                    cnt_val = CW'(C_REPEAT - 1);
                end
            end
            S_REST: begin
                if (cnt_done) begin
                    st_d = S_IDLE;
                end
            end
            default: begin
                st_d = S_IDLE;
            end
        endcase
    end

    // set wins over clear for the pending start
    assign pend_d = start_req || (pend_q && !go);
    // droop warning when high-idle charge ages past the limit
    assign droop_d = (mode_q != FPS_LOW_IDLE) && (idle_q >= 16'(DROOP_CYC - C_PULSE));

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            st_q <= S_IDLE;
            clk_q <= 1'b1;
            pend_q <= 1'b0;
            valid_q <= 1'b0;
            res_q <= '0;
            droop_q <= 1'b0;
        end else begin
            st_q <= st_d;
            clk_q <= clk_d;
            pend_q <= pend_d;
            valid_q <= valid_d && !(rd_data && !capture);
            res_q <= res_d;
            droop_q <= droop_d;
        end
    end

    // mode changes only while idle so a sequence is never cut
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            mode_q <= FPS_HIGH_IDLE;
            keep_q <= 1'b0;
        end else if (wr_ctrl && !busy) begin
            mode_q <= fps_mode_t'(WDATA[B_MODE1:B_MODE0]);
            keep_q <= WDATA[B_KEEP];
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            idle_q <= '0;
        end else if (st_q != S_IDLE) begin
            idle_q <= '0;
        end else if (idle_q != 16'hffff) begin
            idle_q <= idle_q + 16'h0001;
        end
    end

    // pin synchronisers
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            lo_m_q <= '0;
            lo_s_q <= '0;
            up_m_q <= '0;
            up_s_q <= '0;
        end else begin
            lo_m_q <= LOWER_PINS;
            lo_s_q <= lo_m_q;
            up_m_q <= UPPER_PINS;
            up_s_q <= up_m_q;
        end
    end

    // enables follow the synchronised lower overflow
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            oe_sel_q <= 1'b0;
        end else begin
            oe_sel_q <= lo_s_q.range_exceeded_flag;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            rdata_q <= '0;
        end else if (RD) begin
            unique case (ADDR)
                A_CTRL: rdata_q <= ctrl_word;
                A_STAT: rdata_q <= stat_word;
                A_DATA: rdata_q <= data_word;
                default: rdata_q <= '0;
            endcase
        end else begin
            rdata_q <= '0;
        end
    end

    assign RDATA = rdata_q;
    assign CONV_CLK = clk_q;
    assign LOWER_OE_N = oe_sel_q;
    assign UPPER_OE = oe_sel_q;

    chk_fast_pulse: assert property (@(posedge CLK) disable iff (RST)
        (st_q == S_IDLE && go && mode_q == FPS_HIGH_IDLE) |=> !CONV_CLK)
        else $error("fast mode conversion did not start with low pulse");
    chk_low_idle: assert property (@(posedge CLK) disable iff (RST)
        (st_q == S_IDLE && mode_q == FPS_LOW_IDLE && !go) |=> !CONV_CLK)
        else $error("low idle mode not holding clock low");
    chk_two_pulse: assert property (@(posedge CLK) disable iff (RST)
        (st_q == S_P2) |-> two_pulse && CONV_CLK != idle_level)
        else $error("second pulse outside two pulse mode");
    chk_high_idle: assert property (@(posedge CLK) disable iff (RST)
        (st_q == S_IDLE && mode_q == FPS_HIGH_IDLE2 && $past(st_q) == S_IDLE
            && $past(mode_q) == FPS_HIGH_IDLE2) |-> CONV_CLK)
        else $error("third mode not idling high");
    chk_valid_late: assert property (@(posedge CLK) disable iff (RST)
        $rose(valid_q) |-> $past(st_q) == S_DELAY)
        else $error("valid raised before output delay");
    chk_msb_pick: assert property (@(posedge CLK) disable iff (RST)
        (st_q == S_DELAY && cnt_done) |=> res_q.code[4] == $past(lo_over))
        else $error("msb not lower overflow");
    chk_oe_pair: assert property (@(posedge CLK) disable iff (RST)
        LOWER_OE_N == UPPER_OE && (st_q != S_REST || UPPER_OE == res_q.code[4]))
        else $error("enables disagree");
    chk_seq_bound: assert property (@(posedge CLK) disable iff (RST)
        (st_q == S_IDLE && go) |-> ##[4:12] st_q == S_IDLE)
        else $error("sequence overran its bound");
    // clock level per phase, and rest length
    chk_p1_level: assert property (@(posedge CLK) disable iff (RST)
        (st_q == S_P1) |-> CONV_CLK != idle_level)
        else $error("first pulse at idle level");
    chk_gap_level: assert property (@(posedge CLK) disable iff (RST)
        (st_q == S_GAP) |-> CONV_CLK == idle_level)
        else $error("gap between pulses not at idle level");
    chk_delay_level: assert property (@(posedge CLK) disable iff (RST)
        (st_q == S_DELAY) |-> CONV_CLK == idle_level)
        else $error("clock moved during output delay");
    chk_idle_fast: assert property (@(posedge CLK) disable iff (RST)
        (st_q == S_IDLE && mode_q == FPS_HIGH_IDLE && $past(st_q) == S_IDLE
            && $past(mode_q) == FPS_HIGH_IDLE) |-> CONV_CLK)
        else $error("fast mode not idling high");
    chk_rest_len: assert property (@(posedge CLK) disable iff (RST)
        (st_q == S_REST) |=> st_q == S_IDLE)
        else $error("rest after conversion too long");
    // requests and mode
    chk_mode_hold: assert property (@(posedge CLK) disable iff (RST)
        busy |=> $stable(mode_q))
        else $error("mode changed during a sequence");
    chk_pend_set: assert property (@(posedge CLK) disable iff (RST)
        start_req |=> pend_q)
        else $error("start request lost");
    chk_go_busy: assert property (@(posedge CLK) disable iff (RST)
        go |=> busy)
        else $error("start did not begin a sequence");
    chk_keep_alive: assert property (@(posedge CLK) disable iff (RST)
        (st_q == S_IDLE && keep_q && droop_q && !wr_ctrl) |=> st_q == S_P1)
        else $error("keep alive did not restart");
    chk_droop_low: assert property (@(posedge CLK) disable iff (RST)
        (mode_q == FPS_LOW_IDLE) |=> !droop_q)
        else $error("droop warning in low idle mode");
    // result hand over
    chk_cap_delay: assert property (@(posedge CLK) disable iff (RST)
        $rose(valid_q) |-> $past(st_q, 2) == S_DELAY)
        else $error("capture without full output delay");
    chk_valid_set: assert property (@(posedge CLK) disable iff (RST)
        capture |=> valid_q)
        else $error("capture did not raise valid");
    chk_valid_clear: assert property (@(posedge CLK) disable iff (RST)
        (rd_data && !capture) |=> !valid_q)
        else $error("data read did not clear valid");
    chk_rdata_quiet: assert property (@(posedge CLK) disable iff (RST)
        !RD |=> RDATA == 8'h00)
        else $error("read data outside read cycle");
    cov_fast: cover property (@(posedge CLK) disable iff (RST)
        go && mode_q == FPS_HIGH_IDLE);
    cov_low: cover property (@(posedge CLK) disable iff (RST)
        go && mode_q == FPS_LOW_IDLE);
    cov_over: cover property (@(posedge CLK) disable iff (RST)
        $rose(valid_q) && res_q.code[4]);
    cov_third: cover property (@(posedge CLK) disable iff (RST)
        go && mode_q == FPS_HIGH_IDLE2);
    cov_pend: cover property (@(posedge CLK) disable iff (RST)
        start_req && busy);
endmodule : fps_ctrl

// ### logic/fps_pkg.sv
// fps_pkg: constants and types for the flash converter pulse-mode controller
// assumes a 20 MHz system clock driving every register
package fps_pkg;
    localparam int unsigned CLK_NS = 50;
    // pulse and interval times in ns as documented
    localparam int unsigned T_PULSE_MIN_NS = 20;
    localparam int unsigned T_REPEAT_MIN_NS = 20;
    localparam int unsigned T_DROOP_MAX_NS = 5000;
    localparam int unsigned T_LOWIDLE_NS = 40;
    localparam int unsigned T_HIGHIDLE2_NS = 60;
    localparam int unsigned T_OUT_DELAY_NS = 50;
    // least times round up, longest round down, floor of one cycle
    function automatic int unsigned fps_cyc_up(input int unsigned ns);
        int unsigned c;
        c = (ns + CLK_NS - 1) / CLK_NS;
        return (c < 1) ? 1 : c;
    endfunction : fps_cyc_up
    function automatic int unsigned fps_cyc_dn(input int unsigned ns);
        int unsigned c;
        c = ns / CLK_NS;
        return (c < 1) ? 1 : c;
    endfunction : fps_cyc_dn
    localparam int unsigned C_PULSE = fps_cyc_up(T_PULSE_MIN_NS);
    localparam int unsigned C_REPEAT = fps_cyc_up(T_REPEAT_MIN_NS);
    localparam int unsigned C_DROOP = fps_cyc_dn(T_DROOP_MAX_NS);
    localparam int unsigned C_OUTDLY = fps_cyc_up(T_OUT_DELAY_NS);
    // pin resync, enable flop, then resync of the shared lines once the enables move
    localparam int unsigned C_SETTLE = 4;
    localparam int unsigned CW = 8;
    // register map of the controller
    localparam logic [1:0] A_CTRL = 2'h0;
    localparam logic [1:0] A_STAT = 2'h1;
    localparam logic [1:0] A_DATA = 2'h2;
    localparam int unsigned B_START = 0;
    localparam int unsigned B_MODE0 = 1;
    localparam int unsigned B_MODE1 = 2;
    localparam int unsigned B_KEEP = 3;
    typedef enum logic [1:0] {
        FPS_HIGH_IDLE = 2'b00,
        FPS_LOW_IDLE = 2'b01,
        FPS_HIGH_IDLE2 = 2'b10,
        FPS_CONT = 2'b11
    } fps_mode_t;
    // pins from the two converters
    typedef struct packed {
        logic [3:0] result_bits;
        logic range_exceeded_flag;
        logic result_changed_flag;
    } fps_pins_t;
    // captured 5-bit cascade result
    typedef struct packed {
        logic [4:0] code;
        logic changed;
    } fps_result_t;
endpackage : fps_pkg

// ### logic/fps_seq_cnt.sv
// fps_seq_cnt: down counter for phase lengths
// assumes load and its value come from the same clock domain
`timescale 1ns/1ns
module fps_seq_cnt
    import fps_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic load,
    input wire logic [fps_pkg::CW-1:0] value,
    output logic done
);
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    assign cnt_d = load ? value : ((cnt_q != '0) ? cnt_q - 1'b1 : cnt_q);
    // done ignores load so a reload on done forms no loop
    assign done = (cnt_q == '0);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule : fps_seq_cnt
